// *** option_bus_pkg.sv ***
package option_bus_pkg;

    // host window and decode ranges
    localparam logic [15:0] WIN_LO  = 16'h4000;
    localparam logic [15:0] WIN_HI  = 16'h7fff;
    localparam logic [15:0] ROM_HI  = 16'h7f7f;
    localparam logic [15:0] IO_LO   = 16'h7f80;
    localparam logic [15:0] IO_HI   = 16'h7fbf;
    localparam logic [15:0] FLAG_LO = 16'h7fc0;

    // register offsets, first byte of each block
    localparam logic [15:0] ARRAY_CONTROL_TWO     = 16'h7f80;
    localparam logic [15:0] ARRAY_CONTROL_ONE     = 16'h7f84;
    localparam logic [15:0] ARRAY_CONTROL_THREE   = 16'h7f88;
    localparam logic [15:0] UNUSED_SLOT           = 16'h7f8c;
    localparam logic [15:0] COUNTER_READ_DATA     = 16'h7f90;
    localparam logic [15:0] COUNTER_READ_STATUS   = 16'h7f92;
    localparam logic [15:0] COUNTER_WRITE_DATA    = 16'h7f94;
    localparam logic [15:0] COUNTER_WRITE_COMMAND = 16'h7f96;
    localparam logic [15:0] ARRAY_STATUS_PORT     = 16'h7f98;
    localparam logic [15:0] INPUT_STEERING_CONTROL = 16'h7f9c;
    localparam logic [15:0] OPTION_ENABLE_FLAG    = 16'h7fc0;

    // select lines: address bits 4..2 pick one of eight slots
    localparam int SEL_LSB  = 2;
    localparam int SEL_MSB  = 4;
    localparam int FLAG_BIT = 7;
    localparam logic [7:0] STEER_RESET = 8'h00;

    // steering control bit positions
    localparam int HW_A_ROUTE  = 7;
    localparam int HW_B_SOURCE = 6;
    localparam int HW_DATA_MSB = 5;
    localparam int HW_DATA_LSB = 2;
    localparam int HW_INH_B    = 1;
    localparam int HW_INH_DLY  = 0;

    // dividers: base by 5 slots, 2.5 as 2 pulses per 5
    localparam logic [2:0] DIV_LAST    = 3'h4;
    localparam logic [4:0] DIV2P5_PAT  = 5'h05;
    localparam logic [2:0] DIV5_HIGH   = 3'h2;
    localparam int         FB_DIVIDE   = 100;
    localparam logic [5:0] FB_HALF_LAST = 6'(FB_DIVIDE / 2 - 1);
    localparam int         INH_DELAY   = 4;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        read;
        logic        strobe;
    } host_bus_s;

    typedef struct packed {
        logic       a_trigger_state;
        logic       b_trigger_state;
        logic       a_sweep_inhibit;
        logic       b_sweep_inhibit;
        logic       word_match;
        logic       word_clock;
        logic       measure_clock;
        logic       force_inhibit;
        logic       page_select;
        logic       sync_mode;
        logic       sync_on_falling;
        logic [2:0] array_status;
    } pin_s;

endpackage

// *** option_bus_decode_and_select.sv ***
`timescale 1ns/1ps
// Contract
// - buffer direction follows host read/write: toward host on reads
// - buffer enabled only when option selected and address 4000-7fff
// - write in 7fc0-7fff latches data bit seven as option flag
// - flag set answers 4000-7fff; flag clear answers only 7fc0-7fff
// - top 128 bytes: upper half is flag, lower 64 are i/o selects
// - rom outputs enabled only 4000-7f7f, never with i/o registers
// - i/o selects decoded incompletely, each repeating in 7f80-7fbf
// - three write-only array registers at 7f80, 7f84, 7f88; 7f8c unused
// - counter read data, read status, write data, write command slots
// - array status read-only, steering control write-only, mirrored above
// - steering register: four mux selects, four array data bits
// - status read returns pattern match and three array status bits
// - counter output selects which 16k rom page appears
// - rom chip enable when option selected and address 4000-7fff
// - base clock divided by 2.5, 5 and 10
// - measurement clock divided by 100 as phase feedback
// - steering bit routes a trigger to array or back to host
// - array b trigger takes b trigger or pattern match, never both
// - inhibit input muxes a, b or delayed a inhibit
// - forced inhibit drives array inhibit high and resets triggers
// - pattern match passed direct or via edge-selectable synchroniser
module option_bus_decode_and_select (
    input  wire logic                    mclk_in,
    input  wire logic                    reset_in,
    input  wire option_bus_pkg::host_bus_s host_bus_in,
    input  wire option_bus_pkg::pin_s    pins_in,
    output logic [7:0]                   host_data_out,
    output logic                         host_data_oe_out,
    output logic                         buffer_to_host_out,
    output logic                         buffer_enable_out,
    output logic                         option_selected_out,
    output logic                         rom_chip_enable_out,
    output logic                         rom_output_enable_out,
    output logic                         rom_page_out,
    output logic [7:0]                   io_select_out,
    output logic [7:0]                   io_write_pulse_out,
    output logic [7:0]                   input_steering_control_out,
    output logic [3:0]                   array_control_data_out,
    output logic                         clk_div2p5_out,
    output logic                         clk_div5_out,
    output logic                         clk_div10_out,
    output logic                         feedback_clk_out,
    output logic                         pump_up_out,
    output logic                         pump_down_out,
    output logic                         array_a_trigger_out,
    output logic                         a_trigger_return_out,
    output logic                         array_b_trigger_out,
    output logic                         array_inhibit_input_out,
    output logic                         trigger_reset_out,
    output logic                         pattern_match_out
);
    import option_bus_pkg::*;

    typedef struct packed {
        host_bus_s       bus_meta;
        host_bus_s       bus_sync;
        pin_s            pin_meta;
        pin_s            pin_sync;
        logic            strobe_prev;
        logic            opt_sel;
        logic [7:0]      steer;
        logic [7:0]      data_out;
        logic            data_oe;
        logic            to_host;
        logic            buf_en;
        logic            rom_ce;
        logic            rom_oe;
        logic            rom_page;
        logic [7:0]      io_sel;
        logic [7:0]      io_wr;
        logic [2:0]      div_cnt;
        logic            div2p5;
        logic            div5;
        logic            div10;
        logic            meas_prev;
        logic [5:0]      fb_cnt;
        logic            fb_clk;
        logic            pump_up;
        logic            pump_dn;
        logic            wclk_prev;
        logic            word_caught;
        logic            pattern;
        logic [INH_DELAY-1:0] inh_dly;
        logic            a_trig;
        logic            a_ret;
        logic            b_trig;
        logic            inhibit;
        logic            trig_reset;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // inclusive address range test
    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // one-hot of the slot index
    function automatic logic [7:0] slot_hot(input logic [2:0] idx);
        slot_hot = 8'h01 << idx;
    endfunction

    // slot index of a register offset
    function automatic logic [2:0] slot_of(input logic [15:0] a);
        slot_of = a[SEL_MSB:SEL_LSB];
    endfunction

    logic [15:0] addr;
    logic        access;
    logic        start;
    logic        in_win;
    logic        in_io;
    logic        in_flag;
    logic        in_rom;
    logic [2:0]  slot;
    logic        ref_fall;
    logic        fb_fall;
    logic        wclk_edge;
    logic        meas_edge;
    logic        pattern_now;
    logic        inh_pick;

    always_comb begin
        state_next = state_reg;

        // pin inputs pass two flops before use
        state_next.bus_meta = host_bus_in;
        state_next.bus_sync = state_reg.bus_meta;
        state_next.pin_meta = pins_in;
        state_next.pin_sync = state_reg.pin_meta;

        // address decode works on the synchronised bus only
        addr    = state_reg.bus_sync.addr;
        access  = state_reg.bus_sync.strobe;
        start   = access & ~state_reg.strobe_prev;
        in_win  = in_range(addr, WIN_LO, WIN_HI);
        in_io   = in_range(addr, IO_LO, IO_HI);
        in_flag = in_range(addr, FLAG_LO, WIN_HI);
        in_rom  = in_range(addr, WIN_LO, ROM_HI);
        slot    = addr[SEL_MSB:SEL_LSB];
        state_next.strobe_prev = access;

        // flag range answers even while deselected
        if (start && !state_reg.bus_sync.read && in_flag) begin
            state_next.opt_sel =
                state_reg.bus_sync.data[FLAG_BIT];
        end

        // direction always tracks the read line
        state_next.to_host = state_reg.bus_sync.read;
        state_next.buf_en  = access & state_reg.opt_sel
                           & in_win;
        state_next.rom_ce  = access & state_reg.opt_sel
                           & in_win;
        // rom stays off over the register region
        state_next.rom_oe  = access & state_reg.opt_sel
                           & in_rom;
        state_next.rom_page = state_reg.pin_sync.page_select;

        // i/o selects held for the access, write pulse on its start
        state_next.io_sel = '0;
        state_next.io_wr  = '0;
        if (access && state_reg.opt_sel && in_io) begin
            state_next.io_sel = slot_hot(slot);
            if (start && !state_reg.bus_sync.read) begin
                state_next.io_wr = slot_hot(slot);
            end
        end

        // steering control register write
        if (start && !state_reg.bus_sync.read && state_reg.opt_sel
                && in_io
                && slot == slot_of(INPUT_STEERING_CONTROL)) begin
            state_next.steer = state_reg.bus_sync.data;
        end

        // only the status slot is driven; write-only slots stay off
        state_next.data_oe = access & state_reg.bus_sync.read
                           & state_reg.opt_sel & in_io
                           & (slot == slot_of(ARRAY_STATUS_PORT));
        state_next.data_out = {4'h0, state_reg.pattern,
                               state_reg.pin_sync.array_status};

        // base dividers share one five-state counter
        if (state_reg.div_cnt == DIV_LAST) begin
            state_next.div_cnt = 3'h0;
            state_next.div10   = ~state_reg.div10;
        end else begin
            state_next.div_cnt = state_reg.div_cnt + 3'h1;
        end
        state_next.div2p5 = DIV2P5_PAT[state_next.div_cnt];
        // high on counts 1..2 so the reset value fits a full period
        state_next.div5   = (state_next.div_cnt != 3'h0)
                          && (state_next.div_cnt <= DIV5_HIGH);
        ref_fall = state_reg.div10 & ~state_next.div10;

        // measurement clock sampled, so only slow rates divide true
        meas_edge = state_reg.pin_sync.measure_clock
                  & ~state_reg.meas_prev;
        state_next.meas_prev = state_reg.pin_sync.measure_clock;
        fb_fall = 1'b0;
        if (meas_edge) begin
            if (state_reg.fb_cnt == FB_HALF_LAST) begin
                state_next.fb_cnt = 6'h00;
                state_next.fb_clk = ~state_reg.fb_clk;
                fb_fall = state_reg.fb_clk;
            end else begin
                state_next.fb_cnt = state_reg.fb_cnt + 6'h01;
            end
        end

        // falling-edge phase detector, both set means both clear
        state_next.pump_up = state_reg.pump_up | ref_fall;
        state_next.pump_dn = state_reg.pump_dn | fb_fall;
        if (state_next.pump_up && state_next.pump_dn) begin
            state_next.pump_up = 1'b0;
            state_next.pump_dn = 1'b0;
        end

        // pattern synchroniser on the chosen word clock edge
        wclk_edge = state_reg.pin_sync.sync_on_falling
                  ? (state_reg.wclk_prev
                     & ~state_reg.pin_sync.word_clock)
                  : (~state_reg.wclk_prev
                     & state_reg.pin_sync.word_clock);
        state_next.wclk_prev = state_reg.pin_sync.word_clock;
        if (wclk_edge) begin
            state_next.word_caught = state_reg.pin_sync.word_match;
        end
        pattern_now = state_reg.pin_sync.sync_mode
                    ? state_reg.word_caught
                    : state_reg.pin_sync.word_match;
        state_next.pattern = pattern_now;

        // a trigger: into the array or looped back, never both
        if (state_reg.steer[HW_A_ROUTE]) begin
            state_next.a_trig = state_reg.pin_sync.a_trigger_state;
            state_next.a_ret  = 1'b1;
        end else begin
            state_next.a_trig = 1'b1;
            state_next.a_ret  =
                state_reg.pin_sync.a_trigger_state;
        end

        // b trigger source is exclusive
        state_next.b_trig = state_reg.steer[HW_B_SOURCE]
                          ? state_reg.pin_sync.b_trigger_state
                          : state_reg.pattern;

        // delayed copy of the a inhibit stands in for the rc delay
        state_next.inh_dly = {state_reg.inh_dly[INH_DELAY-2:0],
                              state_reg.pin_sync.a_sweep_inhibit};
        if (state_reg.steer[HW_INH_B]) begin
            inh_pick = state_reg.pin_sync.b_sweep_inhibit;
        end else if (state_reg.steer[HW_INH_DLY]) begin
            inh_pick = state_reg.inh_dly[INH_DELAY-1];
        end else begin
            inh_pick = state_reg.pin_sync.a_sweep_inhibit;
        end

        // forced inhibit overrides the mux and resets trigger logic
        state_next.inhibit = state_reg.pin_sync.force_inhibit
                           | inh_pick;
        state_next.trig_reset =
            state_reg.pin_sync.force_inhibit;
    end

    // single register for all state; flag clears on reset
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign host_data_out              = state_reg.data_out;
    assign host_data_oe_out           = state_reg.data_oe;
    assign buffer_to_host_out         = state_reg.to_host;
    assign buffer_enable_out          = state_reg.buf_en;
    assign option_selected_out        = state_reg.opt_sel;
    assign rom_chip_enable_out        = state_reg.rom_ce;
    assign rom_output_enable_out      = state_reg.rom_oe;
    assign rom_page_out               = state_reg.rom_page;
    assign io_select_out              = state_reg.io_sel;
    assign io_write_pulse_out         = state_reg.io_wr;
    assign input_steering_control_out = state_reg.steer;
    assign array_control_data_out     =
        state_reg.steer[HW_DATA_MSB:HW_DATA_LSB];
    assign clk_div2p5_out             = state_reg.div2p5;
    assign clk_div5_out               = state_reg.div5;
    assign clk_div10_out              = state_reg.div10;
    assign feedback_clk_out           = state_reg.fb_clk;
    assign pump_up_out                = state_reg.pump_up;
    assign pump_down_out              = state_reg.pump_dn;
    assign array_a_trigger_out        = state_reg.a_trig;
    assign a_trigger_return_out       = state_reg.a_ret;
    assign array_b_trigger_out        = state_reg.b_trig;
    assign array_inhibit_input_out    = state_reg.inhibit;
    assign trigger_reset_out          = state_reg.trig_reset;
    assign pattern_match_out          = state_reg.pattern;

endmodule

// *** option_bus_decode_and_select_assertions.sv ***
`timescale 1ns/1ps
module option_bus_decode_and_select_assertions
    import option_bus_pkg::*;
(
    input wire logic                      mclk_in,
    input wire logic                      reset_in,
    input wire option_bus_pkg::host_bus_s host_bus_in,
    input wire option_bus_pkg::pin_s      pins_in,
    input wire logic                      buffer_to_host_out,
    input wire logic                      buffer_enable_out,
    input wire logic                      option_selected_out,
    input wire logic                      rom_chip_enable_out,
    input wire logic                      rom_output_enable_out,
    input wire logic [7:0]                io_select_out,
    input wire logic                      host_data_oe_out,
    input wire logic [7:0]                input_steering_control_out,
    input wire logic [3:0]                array_control_data_out,
    input wire logic                      clk_div2p5_out,
    input wire logic                      clk_div5_out,
    input wire logic                      clk_div10_out,
    input wire logic                      array_inhibit_input_out,
    input wire logic                      trigger_reset_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    logic [15:0] addr_now;
    // host holds the address while decode outputs stand
    assign addr_now = host_bus_in.addr;
    // write into the flag range starts
    sequence s_flag_write;
        $rose(host_bus_in.strobe) && !host_bus_in.read && addr_now >= FLAG_LO;
    endsequence
    property p_flag_capture;
        s_flag_write |-> ##3 option_selected_out == host_bus_in.data[FLAG_BIT];
    endproperty
    a_flag_capture: assert property (p_flag_capture)
        else $error("option flag missed data bit seven");
    property p_deselected;
        !option_selected_out [*2] |-> !buffer_enable_out && !rom_chip_enable_out;
    endproperty
    a_deselected: assert property (p_deselected)
        else $error("enable while option deselected");
    property p_buf_window;
        buffer_enable_out |-> addr_now >= WIN_LO && addr_now <= WIN_HI;
    endproperty
    a_buf_window: assert property (p_buf_window)
        else $error("buffer enabled outside window");
    property p_dir;
        buffer_enable_out |-> buffer_to_host_out == host_bus_in.read;
    endproperty
    a_dir: assert property (p_dir)
        else $error("buffer direction wrong");
    property p_rom_window;
        rom_output_enable_out |-> addr_now >= WIN_LO && addr_now <= ROM_HI
            && io_select_out == 8'h00 && rom_chip_enable_out;
    endproperty
    a_rom_window: assert property (p_rom_window)
        else $error("rom output enable outside rom range");
    property p_rom_ce;
        rom_chip_enable_out |-> buffer_enable_out;
    endproperty
    a_rom_ce: assert property (p_rom_ce)
        else $error("rom chip enable without window");
    property p_io_decode;
        io_select_out != 8'h00 |-> addr_now >= IO_LO && addr_now <= IO_HI
            && io_select_out == 8'h01 << addr_now[SEL_MSB:SEL_LSB];
    endproperty
    a_io_decode: assert property (p_io_decode)
        else $error("io select wrong for address");
    property p_oe_status;
        host_data_oe_out |-> host_bus_in.read && io_select_out == 8'h40;
    endproperty
    a_oe_status: assert property (p_oe_status)
        else $error("data driven outside status read");
    property p_ctl_data;
        $stable(input_steering_control_out) [*2] |-> array_control_data_out
            == input_steering_control_out[HW_DATA_MSB:HW_DATA_LSB];
    endproperty
    a_ctl_data: assert property (p_ctl_data)
        else $error("array data bits differ from steering register");
    // each divider repeats every five or ten base cycles
    property p_div5;
        $rose(clk_div5_out) |-> ##5 $rose(clk_div5_out);
    endproperty
    a_div5: assert property (p_div5)
        else $error("divide by five period wrong");
    property p_div10;
        $rose(clk_div10_out) |-> ##10 $rose(clk_div10_out);
    endproperty
    a_div10: assert property (p_div10)
        else $error("divide by ten period wrong");
    property p_div2p5;
        $rose(clk_div2p5_out) |-> ##1 !clk_div2p5_out ##4 $rose(clk_div2p5_out);
    endproperty
    a_div2p5: assert property (p_div2p5)
        else $error("divide by two and a half pattern wrong");
    property p_force_inh;
        pins_in.force_inhibit [*4] |-> array_inhibit_input_out && trigger_reset_out;
    endproperty
    a_force_inh: assert property (p_force_inh)
        else $error("forced inhibit not applied");
endmodule

// *** host_bus_model.sv ***
`timescale 1ns/1ps
module host_bus_model
    import option_bus_pkg::*;
(
    input  wire logic                  mclk_in,
    output option_bus_pkg::host_bus_s  host_bus_out
);
    host_bus_s bus_reg;
    assign host_bus_out = bus_reg;
    initial bus_reg = '0;
    // address and data settle before strobe since the device syncs them
    task automatic start(input logic [15:0] addr, input logic [7:0] data,
                         input logic read);
        @(posedge mclk_in);
        bus_reg <= '{addr: addr, data: data, read: read, strobe: 1'b0};
        repeat (4) @(posedge mclk_in);
        bus_reg.strobe <= 1'b1;
    endtask
    // address held while decode drains; released data shows its inverse
    task automatic finish();
        @(posedge mclk_in);
        bus_reg.strobe <= 1'b0;
        repeat (4) @(posedge mclk_in);
        bus_reg.data <= ~bus_reg.data;
    endtask
endmodule

// *** option_bus_decode_and_select_test.sv ***
`timescale 1ns/1ps
module option_bus_decode_and_select_test;
    import option_bus_pkg::*;
    logic        mclk_in, reset_in;
    host_bus_s   host_bus;
    pin_s        pins, p;
    logic [7:0]  host_data, io_sel, io_wr, steer, exp;
    logic [3:0]  ctl_data;
    logic        data_oe, to_host, buf_en, opt_sel, rom_ce, rom_oe, rom_page;
    logic        d2p5, d5, d10, fb_clk, pump_up, pump_dn, arr_a, a_ret;
    logic        arr_b, arr_inh, trig_rst, pat, fb_prev;
    logic [31:0] r;
    logic [15:0] addr;
    integer      seed;
    int          miscompares, checks, cycles, n;
    logic [7:0]  steer_tab [6] = '{8'h80, 8'h40, 8'h02, 8'h01, 8'h00, 8'hc3};

    option_bus_decode_and_select dut (.mclk_in, .reset_in,
        .host_bus_in(host_bus), .pins_in(pins), .host_data_out(host_data),
        .host_data_oe_out(data_oe), .buffer_to_host_out(to_host),
        .buffer_enable_out(buf_en), .option_selected_out(opt_sel),
        .rom_chip_enable_out(rom_ce), .rom_output_enable_out(rom_oe),
        .rom_page_out(rom_page), .io_select_out(io_sel),
        .io_write_pulse_out(io_wr), .input_steering_control_out(steer),
        .array_control_data_out(ctl_data), .clk_div2p5_out(d2p5),
        .clk_div5_out(d5), .clk_div10_out(d10), .feedback_clk_out(fb_clk),
        .pump_up_out(pump_up), .pump_down_out(pump_dn),
        .array_a_trigger_out(arr_a), .a_trigger_return_out(a_ret),
        .array_b_trigger_out(arr_b), .array_inhibit_input_out(arr_inh),
        .trigger_reset_out(trig_rst), .pattern_match_out(pat));
    host_bus_model host (.mclk_in, .host_bus_out(host_bus));

    // free running base clock
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    // cut a hang short; whole run needs well under this
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            results();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // let the edge's updates land before looking
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_in);
        #1;
    endtask
    task automatic access(input logic [15:0] a, input logic [7:0] d,
                          input logic rd);
        host.start(a, d, rd);
        tick(5);
    endtask
    task automatic rom_cycle(input logic rd, input logic [7:0] want);
        r = $random(seed);
        access(WIN_LO + 16'(r[15:0] % 16'h3f80), r[23:16], rd);
        check({4'h0, to_host, buf_en, rom_ce, rom_oe}, want);
        check(io_sel, 8'h00);
        host.finish();
    endtask
    task automatic flag_write(input logic v);
        r = $random(seed);
        access(FLAG_LO | {10'h0, r[5:0]}, {v, r[6:0]}, 1'b0);
        check({7'h0, opt_sel}, {7'h0, v});
        host.finish();
    endtask
    // random pin levels, clocks idle, direct pattern path
    task automatic set_pins();
        r = $random(seed);
        p = pin_s'(r[14:0]);
        p.force_inhibit = 1'b0;
        p.sync_mode = 1'b0;
        p.measure_clock = 1'b0;
        @(posedge mclk_in);
        pins <= p;
        tick(10);
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        seed = 32'h99a3c645;
        cycles = 0;
        reset_in = 1'b1;
        pins = '0;
        repeat (5) @(posedge mclk_in);
        reset_in <= 1'b0;
        tick(2);
        check({7'h0, opt_sel}, 8'h00);
        rom_cycle(1'b1, 8'h08);
        flag_write(1'b1);
        rom_cycle(1'b1, 8'h0f);
        rom_cycle(1'b0, 8'h07);
        $display("test window done");
        set_pins();
        for (int s = 0; s < 8; s++) begin
            for (int rd = 0; rd < 2; rd++) begin
                r = $random(seed);
                addr = IO_LO | {10'h0, r[0], 3'(s), r[2:1]};
                access(addr, r[15:8], rd[0]);
                check(io_sel, 8'h01 << s);
                check({6'h0, data_oe, rom_oe}, {6'h0, rd == 1 && s == 6, 1'b0});
                if (rd == 1 && s == 6) begin
                    check(host_data, {4'h0, p.word_match, p.array_status});
                end
                host.finish();
                if (s == 7 && rd == 0) check(steer, r[15:8]);
            end
        end
        $display("test io map done");
        foreach (steer_tab[i]) begin
            access(INPUT_STEERING_CONTROL, steer_tab[i], 1'b0);
            host.finish();
            set_pins();
            exp = {2'h0, p.page_select, p.word_match,
                   steer_tab[i][HW_A_ROUTE] ? p.a_trigger_state : 1'b1,
                   steer_tab[i][HW_A_ROUTE] ? 1'b1 : p.a_trigger_state,
                   steer_tab[i][HW_B_SOURCE] ? p.b_trigger_state : p.word_match,
                   steer_tab[i][HW_INH_B] ? p.b_sweep_inhibit : p.a_sweep_inhibit};
            check({2'h0, rom_page, pat, arr_a, a_ret, arr_b, arr_inh}, exp);
            check({4'h0, ctl_data}, {4'h0, steer_tab[i][5:2]});
        end
        @(posedge mclk_in);
        pins.force_inhibit <= 1'b1;
        tick(6);
        check({6'h0, arr_inh, trig_rst}, 8'h03);
        @(posedge mclk_in);
        pins.force_inhibit <= 1'b0;
        $display("test steering done");
        flag_write(1'b0);
        rom_cycle(1'b1, 8'h08);
        flag_write(1'b1);
        @(posedge mclk_in);
        reset_in <= 1'b1;
        tick(2);
        @(posedge mclk_in);
        reset_in <= 1'b0;
        tick(2);
        check({7'h0, opt_sel}, 8'h00);
        check(steer, STEER_RESET);
        $display("test reset done");
        // count feedback toggles over 425 measure clock rises
        n = 0;
        fb_prev = fb_clk;
        repeat (850) begin
            @(posedge mclk_in);
            pins.measure_clock <= ~pins.measure_clock;
            tick(1);
            if (fb_clk !== fb_prev) n++;
            fb_prev = fb_clk;
        end
        check(8'(n), 8'(425 / (FB_DIVIDE / 2)));
        $display("test feedback done");
        results();
    end
endmodule

bind option_bus_decode_and_select option_bus_decode_and_select_assertions chk (
    .mclk_in, .reset_in, .host_bus_in, .pins_in, .buffer_to_host_out,
    .buffer_enable_out, .option_selected_out, .rom_chip_enable_out,
    .rom_output_enable_out, .io_select_out, .host_data_oe_out,
    .input_steering_control_out, .array_control_data_out, .clk_div2p5_out,
    .clk_div5_out, .clk_div10_out, .array_inhibit_input_out,
    .trigger_reset_out);
